// File: common/isdn_irq_params.svh
// Register offsets, reset values and bit positions of the interrupt block
`ifndef ISDN_IRQ_PARAMS_SVH
`define ISDN_IRQ_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define U_STAT_ADDR 5'h13
`define U_MASK_ADDR 5'h14
`define ST_STAT_ADDR 5'h15
`define ST_MASK_ADDR 5'h16
`define M_STAT_ADDR 5'h17
`define M_MASK_ADDR 5'h18
`define GLOBAL_ADDR 5'h19

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define U_W 6
`define ST_W 4
`define M_W 3
`define U_MASK_RST 6'h3f
`define ST_MASK_RST 4'hf
`define M_MASK_RST 3'h7
`define QBITS_RST 4'hf

// ----------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------
`define ST_SOM_BIT 0
`define ST_QSC_BIT 1
`define ST_FECV_BIT 2
`define ST_I4C_BIT 3
`define M_QUIET_BIT 0
`define M_LOSS_BIT 1
`define M_EXIT_BIT 2
`define G_U_BIT 0
`define G_ST_BIT 1
`define G_M_BIT 2

`endif

// File: common/isdn_irq_pkg.sv
// Types shared by the interrupt status and mask block
package isdn_irq_pkg;
   typedef logic [4:0] reg_addr_t;  // Register address
   typedef logic [7:0] reg_data_t;  // Register data byte
   typedef logic [3:0] qbits_t;     // Four received Q bits
endpackage

// File: common/irq_bank_if.sv
// Connection between the controller and one status/mask bank
`timescale 1ns/10ps
interface irq_bank_if #(parameter int W = 4);
   logic [W-1:0] set;         // Event pulses, one per bit
   logic [W-1:0] clr;         // Clear request per bit
   logic mask_we;             // Mask write strobe
   logic [W-1:0] mask_wd;     // Mask write data
   logic [W-1:0] status;      // Sticky status bits
   logic [W-1:0] status_nxt;  // Status value after this edge
   logic [W-1:0] mask;        // Mask bits, 1 disables
   modport bank (
      input set, clr, mask_we, mask_wd,
      output status, status_nxt, mask
   );
   modport ctrl (
      output set, clr, mask_we, mask_wd,
      input status, status_nxt, mask
   );
endinterface

// File: design/irq_status_bank.sv
// One bank of sticky status bits with its mask register
`timescale 1ns/10ps
module irq_status_bank #(
   parameter int W = 4,
   parameter logic [W-1:0] MASK_RST = '1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Controller side
   irq_bank_if.bank bus
);

   logic [W-1:0] status_q;  // Sticky status
   logic [W-1:0] mask_q;    // Mask, 1 disables

   // Set wins over clear so no event is lost
   always_comb begin
      bus.status_nxt = (status_q & ~bus.clr) | bus.set;
   end

   // Status bits, all cleared in reset
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         status_q <= '0;
      end else begin
         status_q <= bus.status_nxt;
      end
   end

   // Mask bits, disabled in reset
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         mask_q <= MASK_RST;
      end else if (bus.mask_we) begin
         mask_q <= bus.mask_wd;
      end
   end

   assign bus.status = status_q;
   assign bus.mask = mask_q;

endmodule // irq_status_bank

// File: design/isdn_interrupt_status_mask.sv
// Interrupt status, mask and summary registers of the transceiver
//
// How it works
// - U mask bits: 0 enables, 1 disables, default 1
// - S/T and maintenance status cleared in reset
// - Start of multiframe sets bit 0, read clears
// - Q bits differing from last multiframe set bit 1
// - Code violations set bit 2 at multiframe boundary
// - Violation check only without multiframe disable, Loop2
// - INFO 4 state change sets bit 3
// - S/T mask bits: 0 enables, 1 disables, default 1
// - Quiet mode request sets maintenance bit 0
// - SN1 tone request sets maintenance bit 1
// - Exit maintenance request sets maintenance bit 2
// - Summary bits show any unmasked active status
// - Maintenance mask bits 0 to 2, default 1
`timescale 1ns/10ps
`include "isdn_irq_params.svh"
module isdn_interrupt_status_mask (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Register port
   input wire isdn_irq_pkg::reg_addr_t addr_i,
   input wire isdn_irq_pkg::reg_data_t wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output isdn_irq_pkg::reg_data_t rdata_o,
   // U-interface event pulses, bit order as status register
   input wire logic [`U_W-1:0] u_event_i,
   // S/T multiframing events
   input wire logic multiframe_start_i,
   input wire isdn_irq_pkg::qbits_t qbits_i,
   input wire logic qbits_valid_i,
   input wire logic code_violation_i,
   input wire logic info4_state_i,
   // Configuration levels
   input wire logic multiframing_disable_i,
   input wire logic loop2_transparent_i,
   // Maintenance machine request pulses
   input wire logic quiet_request_i,
   input wire logic insertion_loss_request_i,
   input wire logic exit_maint_request_i,
   // Interrupt output, active high level
   output logic irq_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   irq_bank_if #(.W(`U_W)) u_bus ();   // U bank
   irq_bank_if #(.W(`ST_W)) st_bus (); // S/T bank
   irq_bank_if #(.W(`M_W)) m_bus ();   // Maintenance bank

   isdn_irq_pkg::reg_data_t rdata_q;   // Read data register
   isdn_irq_pkg::qbits_t qprev_q;      // Q bits of last multiframe
   logic info4_q;                      // Last INFO 4 state
   logic cv_pend_q;                    // Violation seen this interval
   logic irq_q;                        // Interrupt output register
   logic cv_en;                        // Violation check enabled
   logic cv_hit;                       // Violation seen incl. now
   logic qchg;                         // Q bits differ
   logic [`ST_W-1:0] st_set;           // S/T event vector
   logic u_pend;                       // Unmasked U status
   logic st_pend;                      // Unmasked S/T status
   logic m_pend;                       // Unmasked maint status
   logic [7:0] u_clr, st_clr, m_clr;   // Clear requests, full byte

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------

   // True when a strobe addresses the given register
   function automatic logic acc(
      input logic stb,
      input isdn_irq_pkg::reg_addr_t a,
      input isdn_irq_pkg::reg_addr_t target
   );
      acc = stb && (a == target);
   endfunction

   // Per bit clear: read clears all, writing a one clears that bit
   function automatic logic [7:0] clr_of(
      input logic rd,
      input logic wr,
      input isdn_irq_pkg::reg_data_t wd
   );
      clr_of = {8{rd}} | (wr ? wd : 8'h00);
   endfunction

   // ----------------------------------------------------------------
   // U bank
   // ----------------------------------------------------------------

   // U events set their bits whatever the mask holds
   assign u_bus.set = u_event_i;
   assign u_clr = clr_of(acc(re_i, addr_i, `U_STAT_ADDR),
      acc(we_i, addr_i, `U_STAT_ADDR), wdata_i);
   assign u_bus.clr = u_clr[`U_W-1:0];
   // Mask takes the low six data bits
   assign u_bus.mask_we = acc(we_i, addr_i, `U_MASK_ADDR);
   assign u_bus.mask_wd = wdata_i[`U_W-1:0];

   // Bank with all sources disabled after reset
   irq_status_bank #(
      .W(`U_W),
      .MASK_RST(`U_MASK_RST)
   ) u_bank (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .bus(u_bus)
   );

   // ----------------------------------------------------------------
   // S/T multiframing events
   // ----------------------------------------------------------------

   // Violations count only with multiframing on and no Loop2
   assign cv_en = !multiframing_disable_i && !loop2_transparent_i;
   assign cv_hit = cv_en && (cv_pend_q || code_violation_i);
   // Q bits compared against the previous multiframe
   assign qchg = qbits_valid_i && !multiframing_disable_i &&
      (qbits_i != qprev_q);

   // Event vector, bit positions as in the status register
   always_comb begin
      st_set = '0;
      st_set[`ST_SOM_BIT] = multiframe_start_i;
      st_set[`ST_QSC_BIT] = qchg;
      // Violations reach the flag only on a boundary
      st_set[`ST_FECV_BIT] = multiframe_start_i && cv_hit;
      st_set[`ST_I4C_BIT] = info4_state_i != info4_q;
   end

   // Violation seen within the current multiframe interval
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         cv_pend_q <= 1'b0;
      end else if (!cv_en || multiframe_start_i) begin
         // Boundary or disabled check restarts the interval
         cv_pend_q <= 1'b0;
      end else if (code_violation_i) begin
         cv_pend_q <= 1'b1;
      end
   end

   // Q bits of the last completed multiframe, all ones in reset
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         qprev_q <= `QBITS_RST;
      end else if (multiframing_disable_i) begin
         // Held at all ones while multiframing is off
         qprev_q <= `QBITS_RST;
      end else if (qbits_valid_i) begin
         qprev_q <= qbits_i;
      end
   end

   // Last INFO 4 state for change detection
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         info4_q <= 1'b0;
      end else begin
         info4_q <= info4_state_i;
      end
   end

   // ----------------------------------------------------------------
   // S/T bank
   // ----------------------------------------------------------------
   assign st_bus.set = st_set;
   assign st_clr = clr_of(acc(re_i, addr_i, `ST_STAT_ADDR),
      acc(we_i, addr_i, `ST_STAT_ADDR), wdata_i);
   assign st_bus.clr = st_clr[`ST_W-1:0];
   assign st_bus.mask_we = acc(we_i, addr_i, `ST_MASK_ADDR);
   assign st_bus.mask_wd = wdata_i[`ST_W-1:0];

   // Status cleared and mask disabled in reset
   irq_status_bank #(
      .W(`ST_W),
      .MASK_RST(`ST_MASK_RST)
   ) st_bank (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .bus(st_bus)
   );

   // ----------------------------------------------------------------
   // Maintenance bank
   // ----------------------------------------------------------------
   assign m_bus.set = {exit_maint_request_i,
      insertion_loss_request_i,
      quiet_request_i};
   assign m_clr = clr_of(acc(re_i, addr_i, `M_STAT_ADDR),
      acc(we_i, addr_i, `M_STAT_ADDR), wdata_i);
   assign m_bus.clr = m_clr[`M_W-1:0];
   assign m_bus.mask_we = acc(we_i, addr_i, `M_MASK_ADDR);
   assign m_bus.mask_wd = wdata_i[`M_W-1:0];

   // Status cleared and mask disabled in reset
   irq_status_bank #(
      .W(`M_W),
      .MASK_RST(`M_MASK_RST)
   ) m_bank (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .bus(m_bus)
   );

   // ----------------------------------------------------------------
   // Summary and interrupt
   // ----------------------------------------------------------------

   // Summary bits come from unmasked status only
   assign u_pend = |(u_bus.status & ~u_bus.mask);
   assign st_pend = |(st_bus.status & ~st_bus.mask);
   assign m_pend = |(m_bus.status & ~m_bus.mask);

   // Interrupt from next values so it tracks status in the same cycle
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         irq_q <= 1'b0;
      end else begin
         // Next mask values too, so a mask write acts at once
         irq_q <= |(u_bus.status_nxt & ~(u_bus.mask_we ? u_bus.mask_wd :
            u_bus.mask)) ||
            |(st_bus.status_nxt & ~(st_bus.mask_we ? st_bus.mask_wd :
            st_bus.mask)) ||
            |(m_bus.status_nxt & ~(m_bus.mask_we ? m_bus.mask_wd :
            m_bus.mask));
      end
   end
   assign irq_o = irq_q;

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------

   // Read data for one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rdata_q <= 8'h00;
      end else if (re_i) begin
         case (addr_i)
            `U_STAT_ADDR: rdata_q <= {2'h0, u_bus.status};
            `U_MASK_ADDR: rdata_q <= {2'h0, u_bus.mask};
            `ST_STAT_ADDR: rdata_q <= {4'h0, st_bus.status};
            `ST_MASK_ADDR: rdata_q <= {4'h0, st_bus.mask};
            `M_STAT_ADDR: rdata_q <= {5'h00, m_bus.status};
            `M_MASK_ADDR: rdata_q <= {5'h00, m_bus.mask};
            // Summary: maintenance, S/T, U from high to low
            `GLOBAL_ADDR: rdata_q <= {5'h00, m_pend, st_pend,
               u_pend};
            // Unmapped addresses read zero
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign rdata_o = rdata_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   u_mask_default_a:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $past(!rst_b_i) |-> u_bus.mask == `U_MASK_RST)
      else $error("U mask not disabled after reset");

   u_mask_write_a:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      we_i && addr_i == `U_MASK_ADDR |=>
      u_bus.mask == $past(wdata_i[`U_W-1:0]))
      else $error("U mask write not taken");

   status_reset_a:
   assert property (@(posedge clk_i)
      !rst_b_i |=> st_bus.status == '0 && m_bus.status == '0)
      else $error("Status not cleared by reset");

   som_set_a:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      multiframe_start_i |=> st_bus.status[`ST_SOM_BIT])
      else $error("Start of multiframe not flagged");

   read_clear_a:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      re_i && addr_i == `ST_STAT_ADDR |=>
      (st_bus.status & ~$past(st_set)) == '0)
      else $error("S/T status not cleared by read");

   qbit_change_a:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      qbits_valid_i && !multiframing_disable_i && qbits_i != qprev_q
      |=> st_bus.status[`ST_QSC_BIT])
      else $error("Q bit change not flagged");

   cv_boundary_a:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(st_bus.status[`ST_FECV_BIT]) |->
      $past(multiframe_start_i))
      else $error("Violation flag off a boundary");

   cv_gate_a:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(st_bus.status[`ST_FECV_BIT]) |->
      $past(!multiframing_disable_i && !loop2_transparent_i))
      else $error("Violation flag while check disabled");

   info4_change_a:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ##1 info4_state_i != $past(info4_state_i) |=>
      st_bus.status[`ST_I4C_BIT])
      else $error("INFO 4 change not flagged");

   st_mask_default_a:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $past(!rst_b_i) |-> st_bus.mask == `ST_MASK_RST)
      else $error("S/T mask not disabled after reset");

   maint_set_a:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      quiet_request_i |=> m_bus.status[`M_QUIET_BIT])
      else $error("Quiet request not flagged");

   loss_set_a:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      insertion_loss_request_i |=> m_bus.status[`M_LOSS_BIT])
      else $error("Tone request not flagged");

   exit_set_a:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      exit_maint_request_i |=> m_bus.status[`M_EXIT_BIT])
      else $error("Exit request not flagged");

   summary_read_a:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      re_i && addr_i == `GLOBAL_ADDR |=>
      rdata_o == {5'h00, $past(m_pend), $past(st_pend), $past(u_pend)})
      else $error("Summary read wrong");

   m_mask_default_a:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $past(!rst_b_i) |-> m_bus.mask == `M_MASK_RST)
      else $error("Maintenance mask not disabled after reset");

   irq_level_a:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ##1 irq_o == (u_pend || st_pend || m_pend))
      else $error("Interrupt does not follow unmasked status");

endmodule // isdn_interrupt_status_mask

// File: testbench/host_model.sv
// Register port master standing in for the host processor
`timescale 1ns/10ps
module host_model (
   // Clock
   input wire logic clk_i,
   // Register port towards the block
   output isdn_irq_pkg::reg_addr_t addr_o,
   output isdn_irq_pkg::reg_data_t wdata_o,
   output logic we_o,
   output logic re_o
);
   // -------------------------------------------------------------
   // Idle values at time zero
   // -------------------------------------------------------------
   initial begin
      addr_o = 5'h00;
      wdata_o = 8'h00;
      we_o = 1'b0;
      re_o = 1'b0;
   end

   // One-cycle write strobe beside address and data
   task automatic wr(input isdn_irq_pkg::reg_addr_t a,
                     input isdn_irq_pkg::reg_data_t d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      we_o <= 1'b1;
      @(posedge clk_i);
      we_o <= 1'b0;
      // Released lines show a changed value, not the last one
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask

   // One-cycle read strobe; the data come back in the next cycle
   task automatic rd(input isdn_irq_pkg::reg_addr_t a);
      @(posedge clk_i);
      addr_o <= a;
      re_o <= 1'b1;
      @(posedge clk_i);
      re_o <= 1'b0;
      addr_o <= ~a;
   endtask
endmodule // host_model

// File: testbench/isdn_interrupt_status_mask_tb.sv
// Self-checking bench of the interrupt status and mask block
`timescale 1ns/10ps
module isdn_interrupt_status_mask_tb;
   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   logic clk_i, rst_b_i, we, re, irq, rd_pend;
   isdn_irq_pkg::reg_addr_t addr;
   isdn_irq_pkg::reg_data_t wdata, rdata;
   isdn_irq_pkg::qbits_t q;
   logic [5:0] u_ev;
   logic [2:0] mreq;
   logic mf_start, qv, cv, i4, mfd, lp2;
   int n_fail, comparisons, cyc;
   int unsigned seed_v, r;
   isdn_irq_pkg::reg_data_t rd_q[$];  // Expected read data
   logic irq_q[$];                    // Expected interrupt levels
   isdn_irq_pkg::reg_addr_t ra[9] = '{5'h13, 5'h14, 5'h15, 5'h16,
      5'h17, 5'h18, 5'h19, 5'h1f, 5'h00};
   isdn_irq_pkg::reg_data_t rv[9] = '{8'h00, 8'h3f, 8'h00, 8'h0f,
      8'h00, 8'h07, 8'h00, 8'h00, 8'h00};

   // -------------------------------------------------------------
   // Design, host model and clock
   // -------------------------------------------------------------
   isdn_interrupt_status_mask i_isdn_interrupt_status_mask (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata),
      .we_i(we), .re_i(re), .rdata_o(rdata), .u_event_i(u_ev),
      .multiframe_start_i(mf_start), .qbits_i(q), .qbits_valid_i(qv),
      .code_violation_i(cv), .info4_state_i(i4),
      .multiframing_disable_i(mfd), .loop2_transparent_i(lp2),
      .quiet_request_i(mreq[0]), .insertion_loss_request_i(mreq[1]),
      .exit_maint_request_i(mreq[2]), .irq_o(irq));
   host_model i_host_model (.clk_i(clk_i), .addr_o(addr),
      .wdata_o(wdata), .we_o(we), .re_o(re));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // -------------------------------------------------------------
   // Compare tasks and closing report
   // -------------------------------------------------------------
   task automatic cmp_rd(input isdn_irq_pkg::reg_data_t e,
                         input isdn_irq_pkg::reg_data_t g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %0t rdata exp %h got %h", $time, e, g);
      end
   endtask
   task automatic cmp_irq(input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %0t irq exp %h got %h", $time, e, g);
      end
   endtask
   task automatic close_out;
      $display("Mismatches %0d, comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // -------------------------------------------------------------
   // Monitor: takes the oldest note when a result appears
   // -------------------------------------------------------------
   always @(posedge clk_i) begin
      rd_pend <= re;
      cyc = cyc + 1;
      // Hang guard, well above the length of the sequence
      if (cyc == 5000) begin
         n_fail++;
         close_out;
      end
   end
   always @(negedge clk_i) begin
      if (rd_pend === 1'b1 && rd_q.size() > 0) cmp_rd(rd_q.pop_front(), rdata);
      if (irq_q.size() > 0) cmp_irq(irq_q.pop_front(), irq);
   end

   // -------------------------------------------------------------
   // Driver tasks
   // -------------------------------------------------------------
   // Read a register and note what it must return
   task automatic rd(input isdn_irq_pkg::reg_addr_t a,
                     input isdn_irq_pkg::reg_data_t e);
      rd_q.push_back(e);
      i_host_model.rd(a);
   endtask
   // Note the interrupt level expected at the next sample
   task automatic exp_irq(input logic e);
      irq_q.push_back(e);
   endtask
   // One-cycle event pulses; st is {q valid, violation, mf start}
   task automatic ev(input logic [5:0] u, input logic [2:0] m,
                     input logic [2:0] st);
      @(posedge clk_i);
      u_ev <= u;
      mreq <= m;
      {qv, cv, mf_start} <= st;
      @(posedge clk_i);
      u_ev <= 6'h00;
      mreq <= 3'h0;
      {qv, cv, mf_start} <= 3'h0;
   endtask
   task automatic do_reset(input int n);
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (n) @(posedge clk_i);
      rst_b_i <= 1'b1;
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      {rst_b_i, u_ev, mreq, mf_start, qv, cv, i4, mfd, lp2} = '0;
      q = 4'h0;
      rd_pend = 1'b0;
      {n_fail, comparisons, cyc} = '0;
      seed_v = $urandom(24);
      do_reset(4);
      // Reset values of the whole map, unmapped places read 0
      foreach (ra[i]) rd(ra[i], rv[i]);
      // U and S/T mask registers keep only their own bits
      r = $urandom();
      i_host_model.wr(5'h14, r[7:0]);
      rd(5'h14, r[7:0] & 8'h3f);
      i_host_model.wr(5'h16, r[15:8]);
      rd(5'h16, r[15:8] & 8'h0f);
      i_host_model.wr(5'h14, 8'h3f);
      i_host_model.wr(5'h16, 8'h0f);
      // Each maintenance request alone; masked still sets status
      for (int i = 0; i < 3; i++) begin
         ev(6'h00, 3'(1 << i), 3'h0);
         exp_irq(1'b0);
         rd(5'h17, 8'(1 << i));
         rd(5'h17, 8'h00);
      end
      // Unmask one maintenance bit at a time
      for (int i = 0; i < 3; i++) begin
         i_host_model.wr(5'h18, 8'(~(3'(1 << i))));
         ev(6'h00, ~(3'(1 << i)), 3'h0);
         exp_irq(1'b0);
         ev(6'h00, 3'(1 << i), 3'h0);
         exp_irq(1'b1);
         rd(5'h19, 8'h04);
         rd(5'h17, 8'h07);
         exp_irq(1'b0);
      end
      i_host_model.wr(5'h18, 8'h07);
      // Multiframe start, then violations only at the boundary
      ev(6'h00, 3'h0, 3'b001);
      rd(5'h15, 8'h01);
      rd(5'h15, 8'h00);
      ev(6'h00, 3'h0, 3'b010);
      rd(5'h15, 8'h00);
      ev(6'h00, 3'h0, 3'b001);
      rd(5'h15, 8'h05);
      // Violation detection off under multiframe disable or Loop2
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_i);
         {lp2, mfd} <= 2'(1 << i);
         // Q change also ignored while multiframing is off
         ev(6'h00, 3'h0, 3'b110);
         ev(6'h00, 3'h0, 3'b001);
         rd(5'h15, 8'(1 + 2 * i));
         {lp2, mfd} <= 2'b00;
      end
      // Q bits differ from the zero history, then repeat
      r = $urandom_range(1, 15);
      q <= r[3:0];
      ev(6'h00, 3'h0, 3'b100);
      rd(5'h15, 8'h02);
      ev(6'h00, 3'h0, 3'b100);
      rd(5'h15, 8'h00);
      // INFO 4 state changes in both directions
      @(posedge clk_i);
      i4 <= 1'b1;
      rd(5'h15, 8'h08);
      rd(5'h15, 8'h00);
      i4 <= 1'b0;
      rd(5'h15, 8'h08);
      // S/T source unmasked drives summary and interrupt
      i_host_model.wr(5'h16, 8'h00);
      ev(6'h00, 3'h0, 3'b001);
      exp_irq(1'b1);
      rd(5'h19, 8'h02);
      rd(5'h15, 8'h01);
      exp_irq(1'b0);
      // Random U events under default and partial mask
      r = $urandom_range(1, 63);
      ev(r[5:0], 3'h0, 3'h0);
      exp_irq(1'b0);
      rd(5'h13, r[7:0]);
      i_host_model.wr(5'h14, 8'h3e);
      ev(6'h01, 3'h0, 3'h0);
      exp_irq(1'b1);
      rd(5'h19, 8'h01);
      rd(5'h13, 8'h01);
      exp_irq(1'b0);
      // Mask write acts on pending status at once; write one clears
      ev(6'h00, 3'h5, 3'h0);
      exp_irq(1'b0);
      i_host_model.wr(5'h18, 8'h03);
      exp_irq(1'b1);
      i_host_model.wr(5'h19, 8'h00);
      rd(5'h19, 8'h04);
      i_host_model.wr(5'h17, 8'h04);
      exp_irq(1'b0);
      rd(5'h17, 8'h01);
      // Reset in mid-run clears status and restores masks
      ev(6'h00, 3'h7, 3'b001);
      do_reset(2);
      exp_irq(1'b0);
      rd(5'h15, 8'h00);
      rd(5'h17, 8'h00);
      rd(5'h16, 8'h0f);
      rd(5'h14, 8'h3f);
      rd(5'h18, 8'h07);
      repeat (3) @(posedge clk_i);
      close_out;
   end
endmodule // isdn_interrupt_status_mask_tb
